// file: core/rcf_pkg.sv
// rcf_pkg: constants and carriers for the reset cause flag capture block
// assumes: 8-bit register port, one system clock, separate power-on reset
package rcf_pkg;

  ////////////////////////////////////////////////////////////////////////
  // register port shape
  localparam int AW = 8;
  localparam int DW = 8;

  ////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [7:0] OFS_RESET_CAUSE = 8'h03;
  localparam logic [7:0] OFS_IRQ_STATUS  = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK    = 8'h21;

  ////////////////////////////////////////////////////////////////////////
  // field positions inside reset_cause_flags, irq status and irq mask
  localparam int BIT_POWER_ON    = 6;
  localparam int BIT_LOW_VOLTAGE = 5;
  localparam int BIT_WATCHDOG    = 3;
  localparam int BIT_OSC_LOSS    = 1;
  localparam int BIT_PLL_LOSS    = 0;

  // implemented bits: 6, 5, 3, 1, 0
  localparam logic [7:0] FLAG_IMPL_MASK = 8'h6b;

  ////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [7:0] FLAG_POR_VALUE   = 8'h60;
  localparam logic [7:0] IRQ_STATUS_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET   = 8'h00;
  localparam logic [7:0] RD_DATA_IDLE     = 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // carriers
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rcf_bus_req_t;

  typedef struct packed {
    logic lvr_core;
    logic lvr_flash;
    logic lvr_io;
    logic wdog;
    logic osc_loss;
    logic pll_loss;
  } rcf_cause_t;

endpackage

// file: core/rcf_sticky_bit.sv
// rcf_sticky_bit: one sticky flag, set by hardware, cleared by software
// assumes: set and clr are synchronous one-cycle requests on clk
`timescale 1ns/1ps

module rcf_sticky_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  logic clk,
  input  logic rst_n,
  // requests
  input  logic set,
  input  logic clr,
  // flag
  output logic q
);

  logic q_reg;
  logic q_next;

  // set wins over a clear in the same cycle, no event is lost
  assign q_next = set | (q_reg & ~clr);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= RESET_VAL;
    end else begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_set_beats_clear: assert property (
    @(posedge clk) disable iff (!rst_n)
    set |=> q_reg)
    else $error("flag lost an event against a clear");

  chk_clear_drops_bit: assert property (
    @(posedge clk) disable iff (!rst_n)
    clr && !set |=> !q_reg)
    else $error("flag not cleared by write one");

  chk_hold_idle: assert property (
    @(posedge clk) disable iff (!rst_n)
    !clr && !set |=> q_reg == $past(q_reg))
    else $error("flag changed with no cause");

endmodule

// file: core/rcf_irq_ctrl.sv
// rcf_irq_ctrl: sticky event status, mask and one level interrupt
// assumes: events are one-cycle pulses, writes are one-cycle strobes
`timescale 1ns/1ps

module rcf_irq_ctrl #(
  parameter int W = 8
) (
  // clock and reset
  input  logic         clk,
  input  logic         rst_n,
  // hardware events
  input  logic [W-1:0] events,
  // software access
  input  logic         wr_status,
  input  logic         wr_mask,
  input  logic [W-1:0] wdata,
  input  logic [W-1:0] impl,
  // state
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic         irq
);

  logic [W-1:0] status_reg;
  logic [W-1:0] status_next;
  logic [W-1:0] mask_reg;
  logic [W-1:0] mask_next;
  logic [W-1:0] clr;
  logic         irq_reg;

  assign clr         = wr_status ? (wdata & impl) : '0;
  // set wins over a clear arriving in the same cycle
  assign status_next = ((status_reg & ~clr) | events) & impl;
  assign mask_next   = wr_mask ? (wdata & impl) : mask_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= rcf_pkg::IRQ_STATUS_RESET;
      mask_reg   <= rcf_pkg::IRQ_MASK_RESET;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= |(status_next & mask_next);
    end
  end

  assign status = status_reg;
  assign mask   = mask_reg;
  assign irq    = irq_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_irq_tracks_status: assert property (
    @(posedge clk) disable iff (!rst_n)
    irq_reg == |(status_reg & mask_reg))
    else $error("interrupt level disagrees with status and mask");

endmodule

// file: core/rcf_reset_cause.sv
// rcf_reset_cause: records which source caused the last reset
// assumes: cause inputs are synchronous one-cycle pulses from the power
// monitor, watchdog and clock monitors; POR_N is also asserted with RST_N
//
// How it works
// - power-on reset sets the power-on flag
// - any of three supply resets sets low-voltage
// - power-on reset also sets the low-voltage flag
// - watchdog reset sets the watchdog flag
// - oscillator clock loss sets oscillator-loss flag
// - pll clock loss sets pll-loss flag
// - power-on reset clears watchdog, oscillator, pll flags
// - flags keep values through a system reset
// - write one clears a flag, zero keeps it
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps

module rcf_reset_cause #(
  parameter int AW = rcf_pkg::AW,
  parameter int DW = rcf_pkg::DW
) (
  // clock and resets
  input  logic          CLK_SYS,
  input  logic          RST_N,
  input  logic          POR_N,
  // reset cause pulses
  input  logic          LVR_CORE,
  input  logic          LVR_FLASH,
  input  logic          LVR_IO,
  input  logic          WDOG_RST,
  input  logic          OSC_LOSS_RST,
  input  logic          PLL_LOSS_RST,
  // register port
  input  logic [AW-1:0] ADDR,
  input  logic [DW-1:0] WR_DATA,
  input  logic          WR_EN,
  input  logic          RD_EN,
  output logic [DW-1:0] RD_DATA,
  // interrupt
  output logic          IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // request and cause carriers

  rcf_pkg::rcf_bus_req_t req;
  rcf_pkg::rcf_cause_t   cause;

  assign req.addr  = ADDR;
  assign req.wdata = WR_DATA;
  assign req.wr    = WR_EN;
  assign req.rd    = RD_EN;

  assign cause.lvr_core  = LVR_CORE;
  assign cause.lvr_flash = LVR_FLASH;
  assign cause.lvr_io    = LVR_IO;
  assign cause.wdog      = WDOG_RST;
  assign cause.osc_loss  = OSC_LOSS_RST;
  assign cause.pll_loss  = PLL_LOSS_RST;

  ////////////////////////////////////////////////////////////////////////
  // address decode

  logic sel_flags;
  logic sel_status;
  logic sel_mask;
  logic wr_flags;
  logic wr_status;
  logic wr_mask;

  assign sel_flags  = req.addr == rcf_pkg::OFS_RESET_CAUSE;
  assign sel_status = req.addr == rcf_pkg::OFS_IRQ_STATUS;
  assign sel_mask   = req.addr == rcf_pkg::OFS_IRQ_MASK;
  assign wr_flags   = req.wr && sel_flags;
  assign wr_status  = req.wr && sel_status;
  assign wr_mask    = req.wr && sel_mask;

  ////////////////////////////////////////////////////////////////////////
  // cause events in register layout

  logic       lvr_any;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;

  // any of the three supply domains counts as one low-voltage cause
  assign lvr_any = cause.lvr_core | cause.lvr_flash | cause.lvr_io;

  // power-on has no running event; it is caught by the reset value
  always_comb begin
    set_vec                           = 8'h00;
    set_vec[rcf_pkg::BIT_LOW_VOLTAGE] = lvr_any;
    set_vec[rcf_pkg::BIT_WATCHDOG]    = cause.wdog;
    set_vec[rcf_pkg::BIT_OSC_LOSS]    = cause.osc_loss;
    set_vec[rcf_pkg::BIT_PLL_LOSS]    = cause.pll_loss;
  end

  // only ones written to implemented bits clear anything
  assign clr_vec = wr_flags ? (req.wdata & rcf_pkg::FLAG_IMPL_MASK) : 8'h00;

  ////////////////////////////////////////////////////////////////////////
  // reset cause flags
  // these flops sit on POR_N only, so a system reset cannot wipe the
  // evidence of its own cause; the price is that they keep logging
  // events while the rest of the block is held in reset

  logic [7:0] flags;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      if (rcf_pkg::FLAG_IMPL_MASK[gi]) begin : g_impl
        // reset value: 1 for power-on and low-voltage, 0 for the rest
        rcf_sticky_bit #(
          .RESET_VAL (rcf_pkg::FLAG_POR_VALUE[gi])
        ) u_flag (
          .clk   (CLK_SYS),
          .rst_n (POR_N),
          .set   (set_vec[gi]),
          .clr   (clr_vec[gi]),
          .q     (flags[gi])
        );
      end else begin : g_unimpl
        assign flags[gi] = 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // interrupt on newly logged causes

  logic [7:0] irq_status;
  logic [7:0] irq_mask;
  logic       irq_int;

  rcf_irq_ctrl #(
    .W (8)
  ) u_irq (
    .clk       (CLK_SYS),
    .rst_n     (RST_N),
    .events    (set_vec),
    .wr_status (wr_status),
    .wr_mask   (wr_mask),
    .wdata     (req.wdata),
    .impl      (rcf_pkg::FLAG_IMPL_MASK),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq_int)
  );

  ////////////////////////////////////////////////////////////////////////
  // read path: data stands only in the cycle after the strobe

  logic [DW-1:0] rd_mux;
  logic [DW-1:0] rd_data_reg;
  logic [DW-1:0] rd_data_next;

  assign rd_mux = sel_flags  ? flags      :
                  sel_status ? irq_status :
                  sel_mask   ? irq_mask   :
                  rcf_pkg::RD_DATA_IDLE;

  assign rd_data_next = req.rd ? rd_mux : rcf_pkg::RD_DATA_IDLE;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rd_data_reg <= rcf_pkg::RD_DATA_IDLE;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  assign RD_DATA = rd_data_reg;
  assign IRQ     = irq_int;

  ////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_flag_read;
    req.rd && sel_flags;
  endsequence

  sequence s_power_on_flag_clear_write;
    wr_flags && req.wdata[rcf_pkg::BIT_POWER_ON];
  endsequence

  // entry into a system reset with no cause or clear pending in the cycle before
  sequence s_sysrst_entry;
    $fell(RST_N) && $past(set_vec) == 8'h00 && $past(clr_vec) == 8'h00;
  endsequence

  sequence s_status_read;
    req.rd && sel_status;
  endsequence

  sequence s_mask_read;
    req.rd && sel_mask;
  endsequence

  sequence s_unmapped_read;
    req.rd && !sel_flags && !sel_status && !sel_mask;
  endsequence

  sequence s_masked_cause;
    (|(set_vec & irq_mask)) && !wr_mask;
  endsequence

  chk_por_sets_power: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N)
    $rose(POR_N) |-> flags[rcf_pkg::BIT_POWER_ON])
    else $error("power-on flag not set after power-on reset");

  chk_lvr_sets_flag: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N)
    (LVR_CORE || LVR_FLASH || LVR_IO) |=> flags[rcf_pkg::BIT_LOW_VOLTAGE])
    else $error("low-voltage flag not set by a supply reset");

  chk_por_sets_lowvolt: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N)
    $rose(POR_N) |-> flags[rcf_pkg::BIT_LOW_VOLTAGE])
    else $error("low-voltage flag not set after power-on reset");

  chk_wdog_sets_flag: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N)
    WDOG_RST |=> flags[rcf_pkg::BIT_WATCHDOG])
    else $error("watchdog flag not set");

  chk_osc_sets_flag: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N)
    OSC_LOSS_RST |=> flags[rcf_pkg::BIT_OSC_LOSS])
    else $error("oscillator-loss flag not set");

  chk_pll_sets_flag: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N)
    PLL_LOSS_RST |=> flags[rcf_pkg::BIT_PLL_LOSS])
    else $error("pll-loss flag not set");

  chk_por_clears_rest: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N)
    $rose(POR_N) |-> flags[rcf_pkg::BIT_WATCHDOG] == 1'b0
      && flags[rcf_pkg::BIT_OSC_LOSS] == 1'b0
      && flags[rcf_pkg::BIT_PLL_LOSS] == 1'b0)
    else $error("watchdog or clock-loss flag survived power-on reset");

  chk_sysrst_keeps_flags: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N)
    s_sysrst_entry |-> $stable(flags))
    else $error("flags changed during a system reset");

  chk_zero_write_keeps: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N || !RST_N)
    wr_flags && !(|set_vec) && ((req.wdata & flags) == 8'h00) |=> $stable(flags))
    else $error("writing zero changed a flag");

  chk_one_write_clears: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N || !RST_N)
    s_power_on_flag_clear_write |=> !flags[rcf_pkg::BIT_POWER_ON])
    else $error("write one left the power-on flag set");

  chk_unimpl_read_zero: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N || !RST_N)
    s_flag_read |=> (RD_DATA & ~rcf_pkg::FLAG_IMPL_MASK) == 8'h00
      && RD_DATA == $past(flags))
    else $error("flag read returned wrong data or unimplemented bits");

  chk_set_beats_write: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N || !RST_N)
    wr_flags && req.wdata[rcf_pkg::BIT_WATCHDOG] && WDOG_RST
      |=> flags[rcf_pkg::BIT_WATCHDOG])
    else $error("watchdog event lost against a clear");

  chk_read_one_cycle: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    !req.rd |=> RD_DATA == rcf_pkg::RD_DATA_IDLE)
    else $error("read data present without a read");

  chk_status_read: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    s_status_read |=> RD_DATA == $past(irq_status))
    else $error("status read returned wrong data");

  chk_mask_read: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    s_mask_read |=> RD_DATA == $past(irq_mask))
    else $error("mask read returned wrong data");

  chk_unmapped_read: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    s_unmapped_read |=> RD_DATA == rcf_pkg::RD_DATA_IDLE)
    else $error("unmapped read returned nonzero data");

  chk_mask_write: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    wr_mask |=> irq_mask == ($past(WR_DATA) & rcf_pkg::FLAG_IMPL_MASK))
    else $error("mask write not stored on implemented bits");

  chk_drop_needs_clear: assert property (
    @(posedge CLK_SYS) disable iff (!POR_N)
    ($past(flags) & ~flags & ~$past(clr_vec)) == 8'h00)
    else $error("flag dropped without a write one");

  chk_status_logs_cause: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    (|set_vec) |=> (irq_status & $past(set_vec)) == $past(set_vec))
    else $error("interrupt status missed a cause");

  chk_irq_on_cause: assert property (
    @(posedge CLK_SYS) disable iff (!RST_N)
    s_masked_cause |=> IRQ)
    else $error("interrupt not raised by a masked-in cause");

endmodule

// file: verification/rcf_reset_cause_bench.sv
// rcf_reset_cause_bench: self-checking bench for the reset cause flag block
// assumes: core/rcf_pkg.sv and the design modules are compiled first
`timescale 1ns/1ps

module rcf_reset_cause_bench;

  ////////////////////////////////////////////////////////////////////////
  // signals
  logic       clk_sys;
  logic       rst_n;
  logic       por_n;
  logic [5:0] cause;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rd_data;
  logic       irq;
  int         fails;
  int         total_checks;

  ////////////////////////////////////////////////////////////////////////
  // design
  rcf_reset_cause u_dut (
    .CLK_SYS      (clk_sys),
    .RST_N        (rst_n),
    .POR_N        (por_n),
    .LVR_CORE     (cause[5]),
    .LVR_FLASH    (cause[4]),
    .LVR_IO       (cause[3]),
    .WDOG_RST     (cause[2]),
    .OSC_LOSS_RST (cause[1]),
    .PLL_LOSS_RST (cause[0]),
    .ADDR         (addr),
    .WR_DATA      (wr_data),
    .WR_EN        (wr_en),
    .RD_EN        (rd_en),
    .RD_DATA      (rd_data),
    .IRQ          (irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe, so it is sampled there
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    check(rd_data, exp);
  endtask

  task automatic pulse(input int i);
    @(posedge clk_sys);
    cause[i] <= 1'b1;
    @(posedge clk_sys);
    cause[i] <= 1'b0;
  endtask

  // power-on reset is always paired with a system reset
  task automatic do_reset(input bit por);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    por_n <= ~por;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    por_n <= 1'b1;
  endtask

  function automatic logic [7:0] cause_bit(input int i);
    if (i >= 3) return 8'h01 << rcf_pkg::BIT_LOW_VOLTAGE;
    if (i == 2) return 8'h01 << rcf_pkg::BIT_WATCHDOG;
    if (i == 1) return 8'h01 << rcf_pkg::BIT_OSC_LOSS;
    return 8'h01 << rcf_pkg::BIT_PLL_LOSS;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_por_values;
    rd_chk(8'h03, 8'h60);
    @(posedge clk_sys);
    #1;
    check(rd_data, 8'h00);
    rd_chk(8'h20, 8'h00);
    rd_chk(8'h21, 8'h00);
    rd_chk(8'h7f, 8'h00);
    wr(8'h7f, 8'hff);
    rd_chk(8'h03, 8'h60);
    check({7'h00, irq}, 8'h00);
  endtask

  task automatic t_w1c;
    wr(8'h03, 8'h00);
    rd_chk(8'h03, 8'h60);
    wr(8'h03, 8'h40);
    rd_chk(8'h03, 8'h20);
    wr(8'h03, 8'hff);
    rd_chk(8'h03, 8'h00);
  endtask

  task automatic t_causes;
    for (int i = 0; i < 6; i++) begin
      pulse(i);
      rd_chk(8'h03, cause_bit(i));
      rd_chk(8'h20, cause_bit(i));
      wr(8'h03, cause_bit(i));
      wr(8'h20, cause_bit(i));
      rd_chk(8'h03, 8'h00);
      rd_chk(8'h20, 8'h00);
    end
  endtask

  task automatic t_irq;
    wr(8'h21, 8'hff);
    rd_chk(8'h21, rcf_pkg::FLAG_IMPL_MASK);
    wr(8'h21, 8'h08);
    pulse(2);
    #1;
    check({7'h00, irq}, 8'h01);
    wr(8'h20, 8'h08);
    #1;
    check({7'h00, irq}, 8'h00);
    wr(8'h21, 8'h00);
    pulse(2);
    #1;
    check({7'h00, irq}, 8'h00);
    rd_chk(8'h20, 8'h08);
    wr(8'h20, 8'h08);
  endtask

  // the watchdog flag is already set, so a lost event would show as a clear
  task automatic t_set_wins;
    @(posedge clk_sys);
    cause[2] <= 1'b1;
    wr_en    <= 1'b1;
    addr     <= 8'h03;
    wr_data  <= 8'h08;
    @(posedge clk_sys);
    cause[2] <= 1'b0;
    wr_en    <= 1'b0;
    rd_chk(8'h03, 8'h08);
    // status bit 3 is set by the cause above, so a lost event shows as zero
    @(posedge clk_sys);
    cause[2] <= 1'b1;
    wr_en    <= 1'b1;
    addr     <= 8'h20;
    wr_data  <= 8'h08;
    @(posedge clk_sys);
    cause[2] <= 1'b0;
    wr_en    <= 1'b0;
    rd_chk(8'h20, 8'h08);
  endtask

  task automatic t_resets;
    pulse(0);
    do_reset(1'b0);
    rd_chk(8'h03, 8'h09);
    rd_chk(8'h20, 8'h00);
    pulse(1);
    do_reset(1'b1);
    rd_chk(8'h03, 8'h60);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // run control
  task automatic results;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    fails        = 0;
    total_checks = 0;
    rst_n        = 1'b0;
    por_n        = 1'b0;
    cause        = 6'h00;
    addr         = 8'h00;
    wr_data      = 8'h00;
    wr_en        = 1'b0;
    rd_en        = 1'b0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    t_por_values();
    t_w1c();
    t_causes();
    t_irq();
    t_set_wins();
    t_resets();
    results();
  end

  // the whole run needs well under a thousand cycles
  initial begin
    #200000;
    fails++;
    results();
  end

endmodule
